// >>> src/mpm_port.sv
// nibble-interface port of the switch: strap decode, clocking, buffers
// Functional notes
// [R1] data moves four bits at a time each way, nibble clock 2.5 MHz or 25 MHz.
// [R2] the sending party marks valid nibbles with enable and bad ones with error.
// [R3] the device drives receive valid for each nibble and receive error for bad ones.
// [R4] in half duplex the PHY-side party raises collision during a collision.
// [R5] the port acts as a PHY toward a MAC, or as a MAC toward an external PHY.
// [R6] only the two clocks, collision and carrier sense change direction with role.
// [R7] interface type comes from two receive-data straps, role from bit 1.
// [R8] the board should strap the speed pin to the 100/10 setting.
// [R9] the strap-selected nibble interface carries 100 and 10 Mbps.
// [R10] transmit pins carry data in, receive pins carry data out, in both roles.
// [R11] as PHY, transmit pins are inputs; clocks, status and receive pins are outputs.
// [R12] as MAC, receive pins go out on the receive clock, transmit pins come in on theirs.
// [R13] each nibble is launched on and sampled at the rising edge of its own clock.
`timescale 1ns/1ps
`default_nettype none

// dual-clock fifo with gray pointers
module mpm_async_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 8
) (
	// write side
	input  wire logic             wclk,
	input  wire logic             wrst_n,
	input  wire logic             w_valid,
	input  wire logic [WIDTH-1:0] w_data,
	output logic                  w_ready,
	// read side
	input  wire logic             rclk,
	input  wire logic             rrst_n,
	output logic                  r_valid,
	output logic [WIDTH-1:0]      r_data,
	input  wire logic             r_ready
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_r;
	logic [AW:0]      wgray_r;
	logic [AW:0]      rbin_r;
	logic [AW:0]      rgray_r;
	logic [AW:0]      rg_s1_r;
	logic [AW:0]      rg_s2_r;
	logic [AW:0]      wg_s1_r;
	logic [AW:0]      wg_s2_r;
	logic             full_r;
	logic             empty_r;

	// pointer arithmetic
	wire            w_push    = w_valid & ~full_r;
	wire            r_pop     = r_ready & ~empty_r;
	wire [AW:0]     wbin_nxt  = wbin_r + {{AW{1'b0}}, w_push};
	wire [AW:0]     rbin_nxt  = rbin_r + {{AW{1'b0}}, r_pop};
	wire [AW:0]     wgray_nxt = to_gray(wbin_nxt);
	wire [AW:0]     rgray_nxt = to_gray(rbin_nxt);
	wire            full_nxt  = wgray_nxt == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
	wire            empty_nxt = rgray_nxt == wg_s2_r;

	assign w_ready = ~full_r;
	assign r_valid = ~empty_r;
	assign r_data  = mem[rbin_r[AW-1:0]];

	// storage has no reset; only pointers and flags need one
	always_ff @(posedge wclk) begin
		if (w_push) begin
			mem[wbin_r[AW-1:0]] <= w_data;
		end
	end

	// write pointer and full flag, registered so ready is a flop
	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_r  <= '0;
			wgray_r <= '0;
			full_r  <= 1'b0;
		end else begin
			wbin_r  <= wbin_nxt;
			wgray_r <= wgray_nxt;
			full_r  <= full_nxt;
		end
	end

	// read pointer brought into the write domain
	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			{rg_s2_r, rg_s1_r} <= '0;
		end else begin
			{rg_s2_r, rg_s1_r} <= {rg_s1_r, rgray_r};
		end
	end

	// read pointer and empty flag
	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_r  <= '0;
			rgray_r <= '0;
			empty_r <= 1'b1;
		end else begin
			rbin_r  <= rbin_nxt;
			rgray_r <= rgray_nxt;
			empty_r <= empty_nxt;
		end
	end

	// write pointer brought into the read domain
	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			{wg_s2_r, wg_s1_r} <= '0;
		end else begin
			{wg_s2_r, wg_s1_r} <= {wg_s1_r, wgray_r};
		end
	end
endmodule

// port top
module mpm_port (
	// system
	input  wire logic       CLOCK,
	input  wire logic       ARST_N,
	// configuration from switch logic
	input  wire logic       CFG_SPEED_100,
	input  wire logic       CFG_HALF_DUPLEX,
	// strap results
	output logic            STRAP_DONE,
	output logic [1:0]      STRAP_IFACE,
	output logic            STRAP_PHY_ROLE,
	output logic            STRAP_SPEED,
	// egress stream, switch to pins
	input  wire logic       EG_VALID,
	input  wire logic [3:0] EG_NIBBLE,
	input  wire logic       EG_ERROR,
	input  wire logic       EG_LAST,
	output logic            EG_READY,
	// ingress stream, pins to switch
	output logic            IG_VALID,
	output logic [3:0]      IG_NIBBLE,
	output logic            IG_ERROR,
	output logic            IG_LAST,
	input  wire logic       IG_READY,
	output logic            IG_DROP,
	// link status
	output logic            LINK_COLLISION,
	output logic            LINK_CARRIER,
	// transmit pins, always inputs
	input  wire logic       PORT_TX_ENABLE_PIN,
	input  wire logic       PORT_TX_ERROR_PIN,
	input  wire logic [3:0] PORT_TX_NIBBLE_PINS,
	// receive pins, always outputs; data doubles as straps
	output logic            PORT_RX_VALID_PIN,
	output logic            PORT_RX_ERROR_PIN,
	input  wire logic [3:0] PORT_RX_NIBBLE_PINS_I,
	output logic [3:0]      PORT_RX_NIBBLE_PINS_O,
	output logic [3:0]      PORT_RX_NIBBLE_PINS_OE,
	// role-dependent pins; clock inputs carry the wire level
	input  wire logic       PORT_TX_CLOCK_PIN_I,
	output logic            PORT_TX_CLOCK_PIN_O,
	output logic            PORT_TX_CLOCK_PIN_OE,
	input  wire logic       PORT_RX_CLOCK_PIN_I,
	output logic            PORT_RX_CLOCK_PIN_O,
	output logic            PORT_RX_CLOCK_PIN_OE,
	input  wire logic       PORT_COLLISION_PIN_I,
	output logic            PORT_COLLISION_PIN_O,
	output logic            PORT_COLLISION_PIN_OE,
	input  wire logic       PORT_CARRIER_SENSE_PIN_I,
	output logic            PORT_CARRIER_SENSE_PIN_O,
	output logic            PORT_CARRIER_SENSE_PIN_OE
);
	localparam int W = mpm_pkg::WORD_W;

	// system domain state
	logic [3:0]              strap_s1_r;
	logic [3:0]              strap_s2_r;
	logic [1:0]              settle_r;
	logic                    link_on_r;
	logic                    phy_oe_r;
	logic [mpm_pkg::DIV_W-1:0] div_r;
	logic                    clk_out_r;
	logic [2:0]              sys_sync1_r;
	logic [2:0]              sys_sync2_r;
	logic                    col_r;
	logic                    crs_r;
	logic                    ovf_s1_r;
	logic                    ovf_s2_r;
	logic                    ovf_s3_r;
	// transmit-clock domain state
	logic                    on_tx_s1_r;
	logic                    on_tx_s2_r;
	logic                    pend_v_r;
	logic [4:0]              pend_r;
	logic                    ovf_tog_r;
	// receive-clock domain state
	logic                    on_rx_s1_r;
	logic                    on_rx_s2_r;
	mpm_pkg::mpm_eg_state_t  eg_st_r;

	// fifo wires
	logic                    ig_w_ready;
	logic                    ig_r_valid;
	logic [W-1:0]            ig_r_data;
	logic                    eg_r_valid;
	logic [W-1:0]            eg_r_data;
	logic                    ig_load;
	logic                    eg_pop;

	// strap decode and role
	wire strap_cap  = ~STRAP_DONE & (settle_r == mpm_pkg::STRAP_SETTLE);
	wire iface_mii  = STRAP_IFACE == mpm_pkg::IFACE_MII;
	wire role_phy   = STRAP_PHY_ROLE == mpm_pkg::ROLE_PHY;
	wire link_on_nx = STRAP_DONE & iface_mii;

	// straps pass two flops, then are caught once after release
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			strap_s1_r <= '0;
			strap_s2_r <= '0;
		end else begin
			strap_s1_r <= PORT_RX_NIBBLE_PINS_I;
			strap_s2_r <= strap_s1_r;
		end
	end

	// settle count lets the synchroniser fill before capture
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			settle_r       <= '0;
			STRAP_DONE     <= 1'b0;
			STRAP_IFACE    <= mpm_pkg::IFACE_MII;
			STRAP_PHY_ROLE <= mpm_pkg::ROLE_PHY;
			STRAP_SPEED    <= 1'b0;
		end else if (!STRAP_DONE) begin
			settle_r <= settle_r + 2'h1;
			if (strap_cap) begin
				STRAP_DONE     <= 1'b1;
				STRAP_IFACE    <= {strap_s2_r[mpm_pkg::STRAP_IFACE_HI], // R7
				                   strap_s2_r[mpm_pkg::STRAP_IFACE_LO]};
				STRAP_PHY_ROLE <= strap_s2_r[mpm_pkg::STRAP_ROLE]; // R7
				STRAP_SPEED    <= strap_s2_r[mpm_pkg::STRAP_SPEED]; // R8
			end
		end
	end

	// pin directions; straps must be released before any drive
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			link_on_r <= 1'b0;
			phy_oe_r  <= 1'b0;
		end else begin
			link_on_r <= link_on_nx; // R9
			phy_oe_r  <= link_on_nx & role_phy; // R5 R6
		end
	end

	assign PORT_RX_NIBBLE_PINS_OE = {4{link_on_r}}; // R10
	assign PORT_TX_CLOCK_PIN_OE      = phy_oe_r; // R6 R11
	assign PORT_RX_CLOCK_PIN_OE      = phy_oe_r; // R6 R11
	assign PORT_COLLISION_PIN_OE     = phy_oe_r; // R6 R11
	assign PORT_CARRIER_SENSE_PIN_OE = phy_oe_r; // R6 R11

	// nibble clock divider; a late speed change wraps at once
	wire [mpm_pkg::DIV_W-1:0] div_end =
		CFG_SPEED_100 ? mpm_pkg::HALF_FAST : mpm_pkg::HALF_SLOW;
	wire div_wrap = div_r >= div_end;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_r     <= mpm_pkg::DIV_ZERO;
			clk_out_r <= 1'b0;
		end else begin
			div_r     <= div_wrap ? mpm_pkg::DIV_ZERO : div_r + 1'b1;
			clk_out_r <= clk_out_r ^ div_wrap; // R1
		end
	end

	// one flop feeds both clock pins so they stay in phase
	assign PORT_TX_CLOCK_PIN_O = clk_out_r; // R11
	assign PORT_RX_CLOCK_PIN_O = clk_out_r; // R11

	// levels from the pins, two flops each: tx enable, col, crs
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			sys_sync1_r <= '0;
			sys_sync2_r <= '0;
		end else begin
			sys_sync1_r <= {PORT_TX_ENABLE_PIN, PORT_COLLISION_PIN_I,
			                PORT_CARRIER_SENSE_PIN_I};
			sys_sync2_r <= sys_sync1_r;
		end
	end

	// rx activity is sampled straight from the pin flop through two stages
	logic rxa_s1_r;
	logic rxa_s2_r;
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			rxa_s1_r <= 1'b0;
			rxa_s2_r <= 1'b0;
		end else begin
			rxa_s1_r <= PORT_RX_VALID_PIN;
			rxa_s2_r <= rxa_s1_r;
		end
	end

	// as PHY we make collision and carrier; as MAC we report the far end's
	wire tx_act  = sys_sync2_r[2];
	wire col_nxt = phy_oe_r ? (CFG_HALF_DUPLEX & tx_act & rxa_s2_r) // R4
	                        : sys_sync2_r[1]; // R12
	wire crs_nxt = phy_oe_r ? (tx_act | rxa_s2_r) : sys_sync2_r[0];

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			col_r <= 1'b0;
			crs_r <= 1'b0;
		end else begin
			col_r <= col_nxt;
			crs_r <= crs_nxt;
		end
	end

	assign PORT_COLLISION_PIN_O     = col_r;
	assign PORT_CARRIER_SENSE_PIN_O = crs_r;
	assign LINK_COLLISION           = col_r;
	assign LINK_CARRIER             = crs_r;

	// transmit-clock domain: enable level crosses in two flops
	always_ff @(posedge PORT_TX_CLOCK_PIN_I or negedge ARST_N) begin
		if (!ARST_N) begin
			on_tx_s1_r <= 1'b0;
			on_tx_s2_r <= 1'b0;
		end else begin
			on_tx_s1_r <= link_on_r;
			on_tx_s2_r <= on_tx_s1_r;
		end
	end

	// one nibble held back so the last of a frame can be marked
	wire       tx_take  = on_tx_s2_r & PORT_TX_ENABLE_PIN; // R2
	wire [W-1:0] ig_w_data = {~PORT_TX_ENABLE_PIN, pend_r};
	wire       ig_drop_now = pend_v_r & ~ig_w_ready;

	always_ff @(posedge PORT_TX_CLOCK_PIN_I or negedge ARST_N) begin
		if (!ARST_N) begin
			pend_v_r  <= 1'b0;
			pend_r    <= '0;
			ovf_tog_r <= 1'b0;
		end else begin
			pend_v_r  <= tx_take; // R13
			pend_r    <= {PORT_TX_ERROR_PIN, PORT_TX_NIBBLE_PINS}; // R2 R12
			ovf_tog_r <= ovf_tog_r ^ ig_drop_now;
		end
	end

	// pin data cannot be stalled, so a full buffer drops and reports
	mpm_async_fifo #(
		.WIDTH (W),
		.DEPTH (mpm_pkg::FIFO_DEPTH)
	) u_ig_fifo (
		.wclk    (PORT_TX_CLOCK_PIN_I),
		.wrst_n  (ARST_N),
		.w_valid (pend_v_r),
		.w_data  (ig_w_data),
		.w_ready (ig_w_ready),
		.rclk    (CLOCK),
		.rrst_n  (ARST_N),
		.r_valid (ig_r_valid),
		.r_data  (ig_r_data),
		.r_ready (ig_load)
	);

	// ingress output stage, refilled when empty or taken
	assign ig_load = ~IG_VALID | IG_READY;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			IG_VALID  <= 1'b0;
			IG_NIBBLE <= mpm_pkg::NIB_ZERO;
			IG_ERROR  <= 1'b0;
			IG_LAST   <= 1'b0;
		end else if (ig_load) begin
			IG_VALID  <= ig_r_valid;
			IG_NIBBLE <= ig_r_data[mpm_pkg::NIB_W-1:0];
			IG_ERROR  <= ig_r_data[mpm_pkg::WORD_ERR];
			IG_LAST   <= ig_r_data[mpm_pkg::WORD_LAST];
		end
	end

	// drop toggle into the system domain, as a one-cycle pulse
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ovf_s1_r <= 1'b0;
			ovf_s2_r <= 1'b0;
			ovf_s3_r <= 1'b0;
			IG_DROP  <= 1'b0;
		end else begin
			ovf_s1_r <= ovf_tog_r;
			ovf_s2_r <= ovf_s1_r;
			ovf_s3_r <= ovf_s2_r;
			IG_DROP  <= ovf_s2_r ^ ovf_s3_r;
		end
	end

	// egress buffer; its ready stalls the switch
	mpm_async_fifo #(
		.WIDTH (W),
		.DEPTH (mpm_pkg::FIFO_DEPTH)
	) u_eg_fifo (
		.wclk    (CLOCK),
		.wrst_n  (ARST_N),
		.w_valid (EG_VALID),
		.w_data  ({EG_LAST, EG_ERROR, EG_NIBBLE}),
		.w_ready (EG_READY),
		.rclk    (PORT_RX_CLOCK_PIN_I),
		.rrst_n  (ARST_N),
		.r_valid (eg_r_valid),
		.r_data  (eg_r_data),
		.r_ready (eg_pop)
	);

	// receive-clock domain: enable level crosses in two flops
	always_ff @(posedge PORT_RX_CLOCK_PIN_I or negedge ARST_N) begin
		if (!ARST_N) begin
			on_rx_s1_r <= 1'b0;
			on_rx_s2_r <= 1'b0;
		end else begin
			on_rx_s1_r <= link_on_r;
			on_rx_s2_r <= on_rx_s1_r;
		end
	end

	// egress sender; an underrun inside a frame is sent as an error nibble
	assign eg_pop = on_rx_s2_r & eg_r_valid;
	wire eg_last = eg_r_data[mpm_pkg::WORD_LAST];
	wire in_send = eg_st_r == mpm_pkg::EG_SEND;

	always_ff @(posedge PORT_RX_CLOCK_PIN_I or negedge ARST_N) begin
		if (!ARST_N) begin
			eg_st_r               <= mpm_pkg::EG_IDLE;
			PORT_RX_VALID_PIN     <= 1'b0;
			PORT_RX_ERROR_PIN     <= 1'b0;
			PORT_RX_NIBBLE_PINS_O <= mpm_pkg::NIB_ZERO;
		end else if (eg_pop) begin
			eg_st_r               <= eg_last ? mpm_pkg::EG_IDLE : mpm_pkg::EG_SEND;
			PORT_RX_VALID_PIN     <= 1'b1; // R3 R13
			PORT_RX_ERROR_PIN     <= eg_r_data[mpm_pkg::WORD_ERR]; // R3
			PORT_RX_NIBBLE_PINS_O <= eg_r_data[mpm_pkg::NIB_W-1:0]; // R1 R12
		end else begin
			eg_st_r               <= on_rx_s2_r ? eg_st_r : mpm_pkg::EG_IDLE;
			PORT_RX_VALID_PIN     <= in_send & on_rx_s2_r;
			PORT_RX_ERROR_PIN     <= in_send & on_rx_s2_r; // R3
			PORT_RX_NIBBLE_PINS_O <= PORT_RX_NIBBLE_PINS_O;
		end
	end
endmodule

`default_nettype wire

// >>> src/mpm_pkg.sv
// constants and types for the nibble-interface port
package mpm_pkg;
	// clock rates, in kHz
	localparam int SYS_CLK_KHZ  = 200000;
	localparam int NIB_FAST_KHZ = 25000;
	localparam int NIB_SLOW_KHZ = 2500;
	// divider terminal counts for one half period of the nibble clock
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] HALF_FAST =
		DIV_W'(SYS_CLK_KHZ / (2 * NIB_FAST_KHZ) - 1);
	localparam logic [DIV_W-1:0] HALF_SLOW =
		DIV_W'(SYS_CLK_KHZ / (2 * NIB_SLOW_KHZ) - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = '0;
	// strap capture
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam logic [1:0] IFACE_MII    = 2'h0;
	localparam logic       ROLE_PHY     = 1'b1;
	localparam int STRAP_IFACE_HI = 3;
	localparam int STRAP_IFACE_LO = 2;
	localparam int STRAP_ROLE     = 1;
	localparam int STRAP_SPEED    = 0;
	// buffered word: {last, error, nibble}
	localparam int NIB_W      = 4;
	localparam int WORD_W     = 6;
	localparam int WORD_ERR   = 4;
	localparam int WORD_LAST  = 5;
	localparam int FIFO_DEPTH = 8;
	localparam logic [NIB_W-1:0] NIB_ZERO = '0;
	typedef enum logic [1:0] {
		EG_IDLE = 2'b01,
		EG_SEND = 2'b10
	} mpm_eg_state_t;
endpackage

// >>> verif/mpm_port_chk.sv
// concurrent checks on the nibble port's pins and strap results
`timescale 1ns/1ps
`default_nettype none

module mpm_port_chk (
	// system
	input wire logic       CLOCK,
	input wire logic       ARST_N,
	// configuration
	input wire logic       CFG_SPEED_100,
	input wire logic       CFG_HALF_DUPLEX,
	// strap results
	input wire logic       STRAP_DONE,
	input wire logic [1:0] STRAP_IFACE,
	input wire logic       STRAP_PHY_ROLE,
	// receive pins
	input wire logic       PORT_RX_VALID_PIN,
	input wire logic       PORT_RX_ERROR_PIN,
	input wire logic [3:0] PORT_RX_NIBBLE_PINS_O,
	input wire logic [3:0] PORT_RX_NIBBLE_PINS_OE,
	// role-dependent pins
	input wire logic       PORT_TX_CLOCK_PIN_O,
	input wire logic       PORT_TX_CLOCK_PIN_OE,
	input wire logic       PORT_RX_CLOCK_PIN_I,
	input wire logic       PORT_RX_CLOCK_PIN_OE,
	input wire logic       PORT_COLLISION_PIN_O,
	input wire logic       PORT_COLLISION_PIN_OE,
	input wire logic       PORT_CARRIER_SENSE_PIN_OE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	// direction of the four role pins follows the captured role
	phy_dir_a: assert property (
		$rose(STRAP_DONE) && STRAP_PHY_ROLE && STRAP_IFACE == mpm_pkg::IFACE_MII
		|=> PORT_TX_CLOCK_PIN_OE && PORT_RX_CLOCK_PIN_OE && PORT_COLLISION_PIN_OE
		&& PORT_CARRIER_SENSE_PIN_OE && PORT_RX_NIBBLE_PINS_OE == 4'hf)
		else $error("role pins not driven in phy role");
	mac_dir_a: assert property (
		STRAP_DONE && !STRAP_PHY_ROLE |-> !PORT_TX_CLOCK_PIN_OE && !PORT_RX_CLOCK_PIN_OE
		&& !PORT_COLLISION_PIN_OE && !PORT_CARRIER_SENSE_PIN_OE)
		else $error("role pin driven in mac role");
	// straps must not be overdriven before capture
	strap_quiet_a: assert property (
		!STRAP_DONE |-> PORT_RX_NIBBLE_PINS_OE == 4'h0 && !PORT_TX_CLOCK_PIN_OE)
		else $error("pin driven before strap capture");
	// nibble clock half periods
	clk_fast_a: assert property (
		$rose(PORT_TX_CLOCK_PIN_O) && PORT_TX_CLOCK_PIN_OE && CFG_SPEED_100
		|=> PORT_TX_CLOCK_PIN_O [*3] ##1 !PORT_TX_CLOCK_PIN_O)
		else $error("fast nibble clock half period wrong");
	clk_slow_a: assert property (
		$rose(PORT_TX_CLOCK_PIN_O) && PORT_TX_CLOCK_PIN_OE && !CFG_SPEED_100
		|-> ##39 PORT_TX_CLOCK_PIN_O ##1 !PORT_TX_CLOCK_PIN_O)
		else $error("slow nibble clock half period wrong");
	// no collision shown in full duplex
	col_full_a: assert property (
		PORT_COLLISION_PIN_OE && !CFG_HALF_DUPLEX |-> !PORT_COLLISION_PIN_O)
		else $error("collision in full duplex");
	// error only qualifies a valid nibble
	rx_err_a: assert property (
		PORT_RX_ERROR_PIN |-> PORT_RX_VALID_PIN)
		else $error("receive error without valid");
	// receive pins move only with a rising receive clock
	rx_launch_a: assert property (
		STRAP_DONE && $changed({PORT_RX_VALID_PIN, PORT_RX_ERROR_PIN, PORT_RX_NIBBLE_PINS_O})
		|-> $rose(PORT_RX_CLOCK_PIN_I))
		else $error("receive pins changed off the clock");
endmodule

bind mpm_port mpm_port_chk mpm_port_chk_i (.*);

`default_nettype wire

// >>> verif/mpm_far_end.sv
// far-end model: a mac or an external phy on the nibble pins
`timescale 1ns/1ps
`default_nettype none

module mpm_far_end (
	// wire-level clocks at the port
	input  wire logic       clk_tx,
	input  wire logic       clk_rx,
	// own clock, used when acting as the phy
	input  wire logic       make_clk,
	output logic            link_clk,
	// port transmit pins, driven here
	output logic            tx_en,
	output logic            tx_er,
	output logic [3:0]      txd,
	// port receive pins, watched here
	input  wire logic       rx_dv,
	input  wire logic       rx_er,
	input  wire logic [3:0] rxd
);
	logic [4:0] got[$];

	// clock stands low while not enabled; odd offset keeps it unrelated
	initial begin
		link_clk = 1'b0;
		tx_en = 1'b0;
		tx_er = 1'b0;
		txd = 4'h0;
		#1.3;
		forever #15 link_clk = make_clk & ~link_clk;
	end

	// every valid nibble taken at the rising receive clock
	always @(posedge clk_rx)
		if (rx_dv === 1'b1)
			got.push_back({rx_er, rxd});

	// frame of n nibbles, value i xor a, error mark on index e
	task automatic send(input int n, input int e);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_tx);
			tx_en <= 1'b1;
			tx_er <= (i == e);
			txd <= 4'(i) ^ 4'ha;
		end
		@(posedge clk_tx);
		tx_en <= 1'b0;
		tx_er <= 1'b1; // stray error with enable low
		txd <= ~txd; // released data must not keep its value
	endtask
endmodule

`default_nettype wire

// >>> verif/mpm_port_tb.sv
// self-checking bench for the nibble port with a far-end model
`timescale 1ns/1ps
`default_nettype none

module mpm_port_tb;
	logic       CLOCK, ARST_N, CFG_SPEED_100, CFG_HALF_DUPLEX;
	logic       STRAP_DONE, STRAP_PHY_ROLE, STRAP_SPEED, EG_VALID, EG_ERROR, EG_LAST;
	logic [1:0] STRAP_IFACE;
	logic [3:0] EG_NIBBLE, IG_NIBBLE, PORT_TX_NIBBLE_PINS, strap, role_oe;
	logic [3:0] PORT_RX_NIBBLE_PINS_I, PORT_RX_NIBBLE_PINS_O, PORT_RX_NIBBLE_PINS_OE;
	logic       EG_READY, IG_VALID, IG_ERROR, IG_LAST, IG_READY, IG_DROP;
	logic       LINK_COLLISION, LINK_CARRIER, PORT_TX_ENABLE_PIN, PORT_TX_ERROR_PIN;
	logic       PORT_RX_VALID_PIN, PORT_RX_ERROR_PIN, make_clk, link_clk, far_col;
	logic       PORT_TX_CLOCK_PIN_I, PORT_TX_CLOCK_PIN_O, PORT_TX_CLOCK_PIN_OE;
	logic       PORT_RX_CLOCK_PIN_I, PORT_RX_CLOCK_PIN_O, PORT_RX_CLOCK_PIN_OE;
	logic       PORT_COLLISION_PIN_I, PORT_COLLISION_PIN_O, PORT_COLLISION_PIN_OE;
	logic       PORT_CARRIER_SENSE_PIN_I, PORT_CARRIER_SENSE_PIN_O, PORT_CARRIER_SENSE_PIN_OE;
	int         errors, n_tests, drops, col_seen;

	// wire levels from both parties' enables; straps act as pulls
	assign PORT_TX_CLOCK_PIN_I = PORT_TX_CLOCK_PIN_OE ? PORT_TX_CLOCK_PIN_O : link_clk;
	assign PORT_RX_CLOCK_PIN_I = PORT_RX_CLOCK_PIN_OE ? PORT_RX_CLOCK_PIN_O : link_clk;
	assign PORT_COLLISION_PIN_I = PORT_COLLISION_PIN_OE ? PORT_COLLISION_PIN_O : far_col;
	assign PORT_CARRIER_SENSE_PIN_I = PORT_CARRIER_SENSE_PIN_OE ?
		PORT_CARRIER_SENSE_PIN_O : PORT_TX_ENABLE_PIN;
	assign PORT_RX_NIBBLE_PINS_I = (PORT_RX_NIBBLE_PINS_OE & PORT_RX_NIBBLE_PINS_O)
		| (~PORT_RX_NIBBLE_PINS_OE & strap);
	assign role_oe = {PORT_TX_CLOCK_PIN_OE, PORT_RX_CLOCK_PIN_OE,
		PORT_COLLISION_PIN_OE, PORT_CARRIER_SENSE_PIN_OE};

	mpm_port mpm_port_i (.*);
	mpm_far_end mpm_far_end_i (.clk_tx(PORT_TX_CLOCK_PIN_I), .clk_rx(PORT_RX_CLOCK_PIN_I),
		.make_clk(make_clk), .link_clk(link_clk), .tx_en(PORT_TX_ENABLE_PIN),
		.tx_er(PORT_TX_ERROR_PIN), .txd(PORT_TX_NIBBLE_PINS), .rx_dv(PORT_RX_VALID_PIN),
		.rx_er(PORT_RX_ERROR_PIN), .rxd(PORT_RX_NIBBLE_PINS_O));

	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end

	// lost nibbles and collisions seen on the wire and reported inside
	always @(posedge CLOCK) begin
		if (IG_DROP === 1'b1)
			drops++;
		if (PORT_COLLISION_PIN_I === 1'b1 && LINK_COLLISION === 1'b1)
			col_seen++;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a wait that ran out ends the run as a failure
	task automatic bound(input logic ok);
		if (ok !== 1'b1) begin
			errors++;
			give_verdict;
		end
	endtask

	// reset with straps on the pins; capture lands four edges after release
	task automatic do_reset(input logic [3:0] s, input logic spd, input logic half);
		@(negedge CLOCK);
		ARST_N = 1'b0;
		strap = s;
		CFG_SPEED_100 = spd;
		CFG_HALF_DUPLEX = half;
		repeat (2) @(negedge CLOCK);
		ARST_N = 1'b1;
		repeat (3) @(negedge CLOCK);
		check("early done", STRAP_DONE, 1'b0);
		@(negedge CLOCK);
		check("done", STRAP_DONE, 1'b1);
		check("iface", STRAP_IFACE, s[3:2]);
		check("role", STRAP_PHY_ROLE, s[1]);
		check("speed", STRAP_SPEED, s[0]);
		repeat (2) @(negedge CLOCK);
	endtask

	// pin directions for role and interface type
	task automatic t_dir(input logic phy, input logic mii);
		check("role oe", role_oe, {4{phy & mii}});
		check("rxd oe", PORT_RX_NIBBLE_PINS_OE, {4{mii}});
	endtask

	// system cycles between two rises of the transmit clock
	task automatic t_period(input int exp);
		int k = 0, r = 0, c = 0;
		logic p = 1'b1;
		while (r < 2 && k < 200) begin
			@(negedge CLOCK);
			k++;
			c++;
			if (PORT_TX_CLOCK_PIN_I && !p) begin
				r++;
				if (r == 1)
					c = 0;
			end
			p = PORT_TX_CLOCK_PIN_I;
		end
		bound(r == 2);
		check("period", 8'(c), 8'(exp));
	endtask

	// offer one egress word and hold it until taken
	task automatic eg_put(input logic [3:0] n, input logic e, input logic l, inout logic full);
		int k = 0;
		@(negedge CLOCK);
		EG_VALID = 1'b1;
		EG_NIBBLE = n;
		EG_ERROR = e;
		EG_LAST = l;
		// ready is judged while settled; the word is taken at the next rise
		while (EG_READY !== 1'b1 && k < 2000) begin
			full = 1'b1;
			@(negedge CLOCK);
			k++;
		end
		bound(k < 2000);
		@(posedge CLOCK);
	endtask

	// twelve words overrun the buffer, then all leave the pins in order
	task automatic t_egress;
		logic full = 1'b0;
		int k = 0;
		mpm_far_end_i.got.delete();
		for (int i = 0; i < 12; i++)
			eg_put(4'(i) ^ 4'h3, i == 5, i == 11, full);
		@(negedge CLOCK);
		EG_VALID = 1'b0;
		check("eg full", full, 1'b1);
		while (mpm_far_end_i.got.size() < 12 && k < 2000) begin
			@(negedge CLOCK);
			k++;
		end
		bound(k < 2000);
		repeat (100) @(negedge CLOCK);
		check("eg count", 8'(mpm_far_end_i.got.size()), 8'h0c);
		for (int i = 0; i < 12; i++)
			check("eg nib", 8'(mpm_far_end_i.got[i]), {3'h0, i == 5, 4'(i) ^ 4'h3});
	endtask

	// a frame waits behind a stalled sink, then drains with its marks
	task automatic t_ingress;
		int k;
		mpm_far_end_i.send(6, 2);
		repeat (20) @(negedge CLOCK);
		IG_READY = 1'b1;
		for (int i = 0; i < 6; i++) begin
			k = 0;
			while (IG_VALID !== 1'b1 && k < 400) begin
				@(negedge CLOCK);
				k++;
			end
			bound(k < 400);
			check("ig word", {IG_LAST, IG_ERROR, IG_NIBBLE}, {i == 5, i == 2, 4'(i) ^ 4'ha});
			@(negedge CLOCK);
		end
		@(negedge CLOCK);
		IG_READY = 1'b0;
		repeat (100) @(negedge CLOCK);
		check("ig idle", IG_VALID, 1'b0);
	endtask

	// a long frame against a stalled sink: kept nibbles in order, the rest counted
	task automatic t_overflow;
		int k = 0, n = 0;
		drops = 0;
		mpm_far_end_i.send(14, 99);
		repeat (20) @(negedge CLOCK);
		IG_READY = 1'b1;
		// a word seen at a fall is taken at the next rise
		while (k < 100) begin
			if (IG_VALID === 1'b1) begin
				check("ovf nib", IG_NIBBLE, 4'(n) ^ 4'ha);
				n++;
			end
			@(negedge CLOCK);
			k++;
		end
		@(negedge CLOCK);
		IG_READY = 1'b0;
		check("ovf sum", 8'(n + drops), 8'h0e);
		check("ovf drop", drops > 0, 1'b1);
	endtask

	initial begin
		{ARST_N, CFG_SPEED_100, CFG_HALF_DUPLEX, EG_VALID, EG_ERROR, EG_LAST} = '0;
		{EG_NIBBLE, strap, IG_READY, make_clk, far_col} = '0;
		{errors, n_tests, drops, col_seen} = '0;
		do_reset(4'h2, 1'b1, 1'b0);
		t_dir(1'b1, 1'b1);
		t_period(8);
		t_egress;
		t_ingress;
		t_overflow;
		// slow phy in half duplex: frames both ways collide
		do_reset(4'h2, 1'b0, 1'b1);
		t_period(80);
		fork
			mpm_far_end_i.send(8, 99);
			t_egress;
		join
		check("collision", col_seen > 0, 1'b1);
		// mac role: the far phy makes both clocks
		make_clk = 1'b1;
		do_reset(4'h1, 1'b1, 1'b1);
		t_dir(1'b0, 1'b1);
		t_egress;
		t_ingress;
		far_col = 1'b1;
		repeat (8) @(negedge CLOCK);
		check("far col", LINK_COLLISION, 1'b1);
		far_col = 1'b0;
		make_clk = 1'b0;
		// other interface type leaves the port idle
		do_reset(4'h6, 1'b1, 1'b0);
		t_dir(1'b1, 1'b0);
		give_verdict;
	end
endmodule

`default_nettype wire
